// [src/edpc_top.sv]
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "edpc_defines.svh"

module edpc_top
    import edpc_pkg::*;
#(
    parameter int IDLE_CYCLES = `EDPC_IDLE_TIME_MS * `EDPC_CLK_MHZ * 1000
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        strap_enable_i,
    input  wire logic        data_event_i,
    input  wire logic        error_event_i,
    input  wire logic        energy_present_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             driver_power_o,
    output logic             ed_pulse_o,
    output logic             irq_o
);

    localparam int CNT_W = 32;

    // control fields
    logic        en_r, en_nxt;
    logic        auto_up_r, auto_up_nxt;
    logic        auto_down_r, auto_down_nxt;
    logic        burst_dis_r, burst_dis_nxt;
    logic [3:0]  err_th_r, err_th_nxt;
    logic [3:0]  data_th_r, data_th_nxt;
    logic        err_met_r, err_met_nxt;
    logic        data_met_r, data_met_nxt;
    logic        strap_done_r, strap_done_nxt;
    // counters
    logic [3:0]  data_cnt_r, data_cnt_nxt;
    logic [3:0]  err_cnt_r, err_cnt_nxt;
    logic [CNT_W-1:0] idle_r, idle_nxt;
    // power state
    edpc_state_t state_r, state_nxt;
    logic        pwr_r, pwr_nxt;
    logic        burst_go;
    logic        pulse;
    logic        busy;
    // bus and interrupts
    logic [31:0] dat_r, dat_nxt;
    logic        ack_r, ack_nxt;
    logic [`EDPC_IRQ_W-1:0] ist_r, ist_nxt;
    logic [`EDPC_IRQ_W-1:0] imask_r, imask_nxt;
    logic        irq_r, irq_nxt;
    logic        ed_pulse_r, ed_pulse_nxt;

    logic        acc, wr_ctrl, rd_ctrl, wr_lo, wr_hi;
    logic        man_go, data_hit, err_hit, pwr_chg;
    logic [15:0] ctrl_view;

    // a held request is taken every other cycle: ack gates the next take
    assign acc     = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_ctrl = acc && wb_we_i && wb_adr_i == `EDPC_ADDR_CTRL;
    assign rd_ctrl = acc && !wb_we_i && wb_adr_i == `EDPC_ADDR_CTRL;
    assign wr_lo   = wr_ctrl && wb_sel_i[0];
    assign wr_hi   = wr_ctrl && wb_sel_i[1];
    assign man_go  = wr_hi && wb_dat_i[`EDPC_BIT_MAN];
    assign data_hit = en_r && (data_cnt_r >= data_th_r);
    assign err_hit  = en_r && (err_cnt_r >= err_th_r);

    assign ctrl_view = {en_r, auto_up_r, auto_down_r, 1'b0, burst_dis_r, pwr_r,
                        err_met_r, data_met_r, err_th_r, data_th_r};

    // control register
    always_comb begin
        en_nxt         = en_r;
        strap_done_nxt = 1'b1;
        auto_up_nxt    = auto_up_r;
        auto_down_nxt  = auto_down_r;
        burst_dis_nxt  = burst_dis_r;
        err_th_nxt     = err_th_r;
        data_th_nxt    = data_th_r;
        // strap is sampled once, on the first edge out of reset
        if (!strap_done_r) begin
            en_nxt = strap_enable_i;
        end
        if (wr_hi) begin
            en_nxt        = wb_dat_i[`EDPC_BIT_EN];
            auto_up_nxt   = wb_dat_i[`EDPC_BIT_AUTO_UP];
            auto_down_nxt = wb_dat_i[`EDPC_BIT_AUTO_DOWN];
            burst_dis_nxt = wb_dat_i[`EDPC_BIT_BURST_DIS];
        end
        if (wr_lo) begin
            err_th_nxt  = wb_dat_i[`EDPC_ERR_HI:`EDPC_ERR_LO];
            data_th_nxt = wb_dat_i[`EDPC_DATA_HI:`EDPC_DATA_LO];
        end
        // set wins over clear on read
        data_met_nxt = (data_met_r && !rd_ctrl) || data_hit;
        err_met_nxt  = (err_met_r && !rd_ctrl) || err_hit;
    end

    // event counters, saturating; reset after long data silence
    always_comb begin
        data_cnt_nxt = data_cnt_r;
        err_cnt_nxt  = err_cnt_r;
        idle_nxt     = idle_r;
        if (!en_r) begin
            data_cnt_nxt = 4'h0;
            err_cnt_nxt  = 4'h0;
            idle_nxt     = '0;
        end else if (data_event_i) begin
            idle_nxt = '0;
            if (data_cnt_r != `EDPC_CNT_MAX) begin
                data_cnt_nxt = data_cnt_r + 4'h1;
            end
            if (error_event_i && err_cnt_r != `EDPC_CNT_MAX) begin
                err_cnt_nxt = err_cnt_r + 4'h1;
            end
        end else if (idle_r >= CNT_W'(IDLE_CYCLES - 1)) begin
            idle_nxt     = '0;
            data_cnt_nxt = 4'h0;
            err_cnt_nxt  = 4'h0;
            // an error in the wrap cycle is not lost: it opens the new count
            if (error_event_i) begin
                err_cnt_nxt = 4'h1;
            end
        end else begin
            idle_nxt = idle_r + 1'b1;
            if (error_event_i && err_cnt_r != `EDPC_CNT_MAX) begin
                err_cnt_nxt = err_cnt_r + 4'h1;
            end
        end
    end

    // power state machine; error threshold drives no action
    always_comb begin
        state_nxt = state_r;
        pwr_nxt   = pwr_r;
        burst_go  = 1'b0;
        pwr_chg   = 1'b0;
        // pulses are gated by pwr_r: none leaves after the first cycle the driver is down, even mid-burst
        ed_pulse_nxt = pulse && pwr_r;
        case (state_r)
            EDPC_DOWN: begin
                if (man_go || (en_r && auto_up_r && data_hit)) begin
                    state_nxt = EDPC_BURST;
                    pwr_nxt   = 1'b1;
                    burst_go  = 1'b1;
                    pwr_chg   = 1'b1;
                end
            end
            EDPC_BURST: begin
                if (man_go) begin
                    state_nxt = EDPC_DOWN;
                    pwr_nxt   = 1'b0;
                    pwr_chg   = 1'b1;
                end else if (!busy) begin
                    state_nxt = EDPC_UP;
                end
            end
            EDPC_UP: begin
                if (man_go || (en_r && auto_down_r && !energy_present_i)) begin
                    state_nxt = EDPC_DOWN;
                    pwr_nxt   = 1'b0;
                    pwr_chg   = 1'b1;
                end
            end
            default: begin
                state_nxt = EDPC_DOWN;
                pwr_nxt   = 1'b0;
            end
        endcase
    end

    edpc_pulse_gen u_pulse (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (burst_go),
        .single_i (burst_dis_r),
        .pulse_o  (pulse),
        .busy_o   (busy)
    );

    // bus slave: answer one cycle after the take
    always_comb begin
        ack_nxt = acc;
        dat_nxt = 32'h0;
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                `EDPC_ADDR_CTRL:     dat_nxt = {16'h0, ctrl_view};
                `EDPC_ADDR_IRQ_STAT: dat_nxt = {29'h0, ist_r};
                `EDPC_ADDR_IRQ_MASK: dat_nxt = {29'h0, imask_r};
                default:             dat_nxt = 32'h0;
            endcase
        end
    end

    // interrupts; an event beats a write-one clear of the same bit
    always_comb begin
        imask_nxt = imask_r;
        ist_nxt   = ist_r;
        if (acc && wb_we_i && wb_adr_i == `EDPC_ADDR_IRQ_STAT && wb_sel_i[0]) begin
            ist_nxt = ist_r & ~wb_dat_i[`EDPC_IRQ_W-1:0];
        end
        if (acc && wb_we_i && wb_adr_i == `EDPC_ADDR_IRQ_MASK && wb_sel_i[0]) begin
            imask_nxt = wb_dat_i[`EDPC_IRQ_W-1:0];
        end
        ist_nxt[`EDPC_IRQ_DATA_MET] = ist_nxt[`EDPC_IRQ_DATA_MET] | data_hit;
        ist_nxt[`EDPC_IRQ_ERR_MET]  = ist_nxt[`EDPC_IRQ_ERR_MET] | err_hit;
        ist_nxt[`EDPC_IRQ_PWR_CHG]  = ist_nxt[`EDPC_IRQ_PWR_CHG] | pwr_chg;
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r         <= 1'b0;
            strap_done_r <= 1'b0;
            auto_up_r    <= `EDPC_RST_AUTO_UP;
            auto_down_r  <= `EDPC_RST_AUTO_DOWN;
            burst_dis_r  <= 1'b0;
            err_th_r     <= `EDPC_RST_THRESH;
            data_th_r    <= `EDPC_RST_THRESH;
            err_met_r    <= 1'b0;
            data_met_r   <= 1'b0;
        end else begin
            en_r         <= en_nxt;
            strap_done_r <= strap_done_nxt;
            auto_up_r    <= auto_up_nxt;
            auto_down_r  <= auto_down_nxt;
            burst_dis_r  <= burst_dis_nxt;
            err_th_r     <= err_th_nxt;
            data_th_r    <= data_th_nxt;
            err_met_r    <= err_met_nxt;
            data_met_r   <= data_met_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_cnt_r   <= 4'h0;
            err_cnt_r    <= 4'h0;
            idle_r       <= '0;
        end else begin
            data_cnt_r   <= data_cnt_nxt;
            err_cnt_r    <= err_cnt_nxt;
            idle_r       <= idle_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r      <= EDPC_DOWN;
            pwr_r        <= 1'b0;
            ed_pulse_r   <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            pwr_r        <= pwr_nxt;
            ed_pulse_r   <= ed_pulse_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r        <= 32'h0;
            ack_r        <= 1'b0;
        end else begin
            dat_r        <= dat_nxt;
            ack_r        <= ack_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_r        <= '0;
            imask_r      <= '0;
            irq_r        <= 1'b0;
        end else begin
            ist_r        <= ist_nxt;
            imask_r      <= imask_nxt;
            irq_r        <= irq_nxt;
        end
    end

    assign wb_dat_o       = dat_r;
    assign wb_ack_o       = ack_r;
    assign driver_power_o = pwr_r;
    assign ed_pulse_o     = ed_pulse_r;
    assign irq_o          = irq_r;

endmodule

// [src/edpc_defines.svh]
`ifndef EDPC_DEFINES_SVH
`define EDPC_DEFINES_SVH

// register byte addresses (printed 1Dh is not a multiple of four: index * 4)
`define EDPC_IDX_CTRL        6'h1D
`define EDPC_ADDR_CTRL       8'h74
`define EDPC_ADDR_IRQ_STAT   8'h80
`define EDPC_ADDR_IRQ_MASK   8'h84

// control register fields
`define EDPC_BIT_EN          15
`define EDPC_BIT_AUTO_UP     14
`define EDPC_BIT_AUTO_DOWN   13
`define EDPC_BIT_MAN         12
`define EDPC_BIT_BURST_DIS   11
`define EDPC_BIT_PWR         10
`define EDPC_BIT_ERR_MET     9
`define EDPC_BIT_DATA_MET    8
`define EDPC_ERR_HI          7
`define EDPC_ERR_LO          4
`define EDPC_DATA_HI         3
`define EDPC_DATA_LO         0

// reset values
`define EDPC_RST_AUTO_UP     1'h1
`define EDPC_RST_AUTO_DOWN   1'h1
`define EDPC_RST_THRESH      4'h1

// interrupt status bits
`define EDPC_IRQ_DATA_MET    0
`define EDPC_IRQ_ERR_MET     1
`define EDPC_IRQ_PWR_CHG     2
`define EDPC_IRQ_W           3

// pulse burst
`define EDPC_BURST_LEN       3'h4
`define EDPC_BURST_ONE       3'h1

// event counters saturate here
`define EDPC_CNT_MAX         4'hF

// counter reset idle time
`define EDPC_IDLE_TIME_MS    2000
`define EDPC_CLK_MHZ         200

`endif

// [src/edpc_pkg.sv]
package edpc_pkg;

    typedef enum logic [1:0] {
        EDPC_DOWN   = 2'b00,
        EDPC_UP     = 2'b01,
        EDPC_BURST  = 2'b10
    } edpc_state_t;

endpackage

// [src/edpc_pulse_gen.sv]
`timescale 1ns/1ps
`include "edpc_defines.svh"

module edpc_pulse_gen (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic single_i,
    output logic      pulse_o,
    output logic      busy_o
);

    logic [2:0] left_r;
    logic [2:0] left_nxt;
    logic       pulse_r;
    logic       pulse_nxt;

    // one pulse every other cycle so the line sees separate pulses
    always_comb begin
        left_nxt  = left_r;
        pulse_nxt = 1'b0;
        if (start_i) begin
            left_nxt = single_i ? `EDPC_BURST_ONE : `EDPC_BURST_LEN;
        end else if (left_r != 3'h0 && !pulse_r) begin
            pulse_nxt = 1'b1;
            left_nxt  = left_r - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_r  <= 3'h0;
            pulse_r <= 1'b0;
        end else begin
            left_r  <= left_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign pulse_o = pulse_r;
    assign busy_o  = (left_r != 3'h0) || pulse_r;

endmodule

// [tb/edpc_line_model.sv]
`timescale 1ns/1ps
module edpc_line_model (
    input  wire logic clk_i,
    output logic      data_event_o,
    output logic      error_event_o,
    output logic      energy_o
);
    initial begin
        data_event_o  = 1'b0;
        error_event_o = 1'b0;
        energy_o      = 1'b1;
    end
    // one idle cycle between events so each is counted once
    task burst(input int nd, input int ne);
        for (int i = 0; i < nd + ne; i++) begin
            @(posedge clk_i);
            data_event_o  <= (i < nd);
            error_event_o <= (i >= nd);
            @(posedge clk_i);
            data_event_o  <= 1'b0;
            error_event_o <= 1'b0;
        end
    endtask
    task level(input logic v);
        @(posedge clk_i);
        energy_o <= v;
    endtask
endmodule

// [tb/edpc_top_chk.sv]
`timescale 1ns/1ps
module edpc_top_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        driver_power_o,
    input wire logic        ed_pulse_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic rd_c;
    assign rd_c = wb_ack_o && !wb_we_i && wb_adr_i == 8'h74;
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_pulse_gap: assert property (ed_pulse_o |=> !ed_pulse_o)
        else $error("pulse longer than one cycle");
    chk_pulse_after_up: assert property ($rose(driver_power_o) |-> ##[1:8] ed_pulse_o)
        else $error("no pulse after power up");
    chk_read_state: assert property (rd_c |-> wb_dat_o[10] == $past(driver_power_o))
        else $error("power bit differs from driver state");
    chk_read_fixed: assert property (rd_c |-> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[12])
        else $error("self clearing or upper bits read nonzero");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h74, 8'h80, 8'h84})
        |-> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
    chk_man_toggle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h74
        && wb_sel_i[1] && wb_dat_i[12] |-> ##[1:3] $changed(driver_power_o))
        else $error("manual toggle ignored");
    chk_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !driver_power_o && !ed_pulse_o && !wb_ack_o && !irq_o) else $error("outputs active in reset");
endmodule
bind edpc_top edpc_top_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .driver_power_o, .ed_pulse_o, .irq_o);

// [tb/edpc_top_tb.sv]
`timescale 1ns/1ps
module edpc_top_tb;
    logic        clk_i, rst_i, strap_i, cyc, stb, we, ack, pwr, pulse, irq, de, ee, ep;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, q, dat_o;
    int          errors, n_tests, n_pulse, seed, t, en, aup, adn, bd, dt, et;

    edpc_top #(.IDLE_CYCLES(50)) DUT (.clk_i, .rst_i, .strap_enable_i(strap_i), .data_event_i(de),
        .error_event_i(ee), .energy_present_i(ep), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .driver_power_o(pwr), .ed_pulse_o(pulse), .irq_o(irq));
    edpc_line_model line (.clk_i, .data_event_o(de), .error_event_o(ee), .energy_o(ep));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (pulse === 1'b1) n_pulse <= n_pulse + 1;

    task close_out;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t no bus acknowledge", $time);
            close_out;
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task wctl(input int man);
        wb(1'b1, 8'h74, {16'h0, en[0], aup[0], adn[0], man[0], bd[0], 3'h0, et[3:0], dt[3:0]});
    endtask
    task rctl(input int p, input int em, input int dm);
        wb(1'b0, 8'h74, 32'h0);
        cmp(q, {16'h0, en[0], aup[0], adn[0], 1'b0, bd[0], p[0], em[0], dm[0], et[3:0], dt[3:0]});
    endtask

    initial begin
        {errors, n_tests, n_pulse, seed} = {32'h0, 32'h0, 32'h0, 32'hDF0E};
        {cyc, stb, we, adr, sel, dat, strap_i, rst_i} = '0;
        strap_i = 1'b1;
        rst_i   = 1'b1;
        {en, aup, adn, bd, dt, et} = {32'h1, 32'h1, 32'h1, 32'h0, 32'h1, 32'h1};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rctl(0, 0, 0);
        wb(1'b1, 8'h10, 32'hFFFF);
        wb(1'b0, 8'h10, 32'h0);
        cmp(q, 32'h0);
        wb(1'b1, 8'h84, 32'h7);
        // crossover selection is software's job outside this block
        {adn, et, dt} = {32'h0, 32'h3, 32'hF};
        wctl(0);
        line.burst(0, 3);
        repeat (3) @(posedge clk_i);
        rctl(0, 1, 0);
        cmp(pwr, 1'b0);
        repeat (60) @(posedge clk_i);
        rctl(0, 1, 0);
        rctl(0, 0, 0);
        wb(1'b0, 8'h80, 32'h0);
        cmp(q, 32'h2);
        wb(1'b1, 8'h80, 32'h7);
        repeat (2) @(posedge clk_i);
        cmp(irq, 1'b0);
        t  = 2 + ($unsigned($random(seed)) % 6);
        dt = t;
        et = 15;
        wctl(0);
        line.burst(t - 1, 0);
        repeat (3) @(posedge clk_i);
        cmp(pwr, 1'b0);
        n_pulse = 0;
        line.burst(1, 0);
        repeat (20) @(posedge clk_i);
        cmp(pwr, 1'b1);
        cmp(n_pulse, 4);
        rctl(1, 0, 1);
        repeat (60) @(posedge clk_i);
        rctl(1, 0, 1);
        rctl(1, 0, 0);
        wb(1'b1, 8'h84, 32'h0);
        repeat (2) @(posedge clk_i);
        cmp(irq, 1'b0);
        wb(1'b1, 8'h84, 32'h7);
        repeat (2) @(posedge clk_i);
        cmp(irq, 1'b1);
        wb(1'b1, 8'h80, 32'h7); // interrupt cleared before manual toggle
        repeat (2) @(posedge clk_i);
        cmp(irq, 1'b0);
        {aup, bd} = {32'h0, 32'h1};
        wctl(1);
        repeat (5) @(posedge clk_i);
        cmp(pwr, 1'b0);
        n_pulse = 0;
        wctl(1);
        repeat (20) @(posedge clk_i);
        cmp(pwr, 1'b1);
        cmp(n_pulse, 1);
        adn = 1;
        wctl(0);
        line.level(1'b0);
        repeat (5) @(posedge clk_i);
        cmp(pwr, 1'b0);
        strap_i <= 1'b0;
        rst_i   <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        {en, aup, adn, bd, dt, et} = {32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h1};
        rctl(0, 0, 0);
        close_out;
    end
endmodule
